// ===== dea_pkg.sv
// Constants and types shared by the disk ECC accumulator files
`default_nettype none
package dea_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_HZ = 5_000_000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int unsigned DIV_W = 4;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned CNT_W = 11;
    localparam logic [CNT_W-1:0] RECORD_MAX_BYTES = 11'd1038;
    localparam logic [2:0] CHECK_BYTES = 3'd4;
    localparam logic [2:0] LAST_BIT = 3'd7;
    localparam logic [ACC_W-1:0] ACC_PRESET = 32'hffff_ffff;
    localparam logic [ACC_W-1:0] POLY_DEFAULT = 32'h1000_0821;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_ACC = 8'h0c;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    localparam logic [7:0] OFF_POLY = 8'h14;

    localparam int unsigned CTRL_DIAG_BIT = 0;
    localparam logic CTRL_RST = 1'b0;
    localparam int unsigned STAT_W = 4;
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam int unsigned STAT_REFUSED_BIT = 1;
    localparam int unsigned STAT_ERR_BIT = 2;
    localparam int unsigned STAT_OVERRUN_BIT = 3;
    localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 4'h0;
    localparam int unsigned CNT_CHK_LSB = 16;
    localparam int unsigned CNT_BUSY_BIT = 24;
    localparam int unsigned CNT_ERR_BIT = 25;

    typedef enum logic [1:0] {
        DEA_IDLE,
        DEA_SHIFT_IN,
        DEA_SHIFT_OUT
    } dea_state_t;
endpackage
`default_nettype wire

// ===== dea_tick_div.sv
// Divider making the one-cycle 5 MHz sequencing enable
`default_nettype none
module dea_tick_div
(
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic tick
);
    import dea_pkg::*;

    logic [DIV_W-1:0] cnt_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (cnt_q == DIV_W'(TICK_DIV - 1))
        begin
            cnt_q <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // dea_tick_div
`default_nettype wire

// ===== dea_acc_step.sv
// One bit step of the 32-bit accumulator
`default_nettype none
module dea_acc_step
#(
    parameter logic [31:0] POLY = 32'h0000_0001
)
(
    input wire logic [31:0] acc,
    input wire logic bit_in,
    input wire logic raw,
    output logic [31:0] acc_next
);
    logic fb;

    always_comb
    begin
        fb = acc[31] ^ bit_in;
        if (raw)
            acc_next = {acc[30:0], bit_in};
        else
            acc_next = {acc[30:0], 1'b0} ^ (fb ? POLY : 32'h0000_0000);
    end
endmodule // dea_acc_step
`default_nettype wire

// ===== dea_ecc_acc.sv
// Disk ECC accumulator: byte port, sequencer and AHB-Lite registers
// Behaviour
// - Strobes count only while the select input is low.
// - Initialisation low loads the accumulator with all ones.
// - Select low marks user data, high marks check or syndrome bytes.
// - Write strobe feeds the port byte into the accumulator.
// - Read strobe puts an accumulator byte onto the port.
// - Busy stands during each byte transfer; strobes then are refused.
// - Error output low when syndrome is clean, high when not.
// - Long-mode select high is normal; low ignores initialisation.
// - Sequencing runs from one 5 MHz timing enable.
// - One shared 8-bit port, driven only during reads.
// - Fixed 32-bit polynomial, four check bytes per record.
// - Any single burst up to 11 bits is detected.
// - Records up to 1038 bytes including check bytes.
// - One byte per eight timing enables, 5 Mbit/s.
// - Generates check bytes, detects errors, gives syndrome bytes.
// - Diagnostic mode passes check bytes through unchanged.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
module dea_ecc_acc
#(
    parameter logic [dea_pkg::ACC_W-1:0] POLY = dea_pkg::POLY_DEFAULT
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic ecc_sel,
    input wire logic preset_n,
    input wire logic long_n,
    input wire logic [dea_pkg::BYTE_W-1:0] data_i,
    output logic [dea_pkg::BYTE_W-1:0] data_o,
    output logic data_oe,
    output logic busy,
    output logic err,
    output logic irq
);
    import dea_pkg::*;

    dea_state_t state_q;
    logic tick;
    logic wr_lvl, rd_lvl, wr_q, rd_q, wr_start, rd_start;
    logic accept_wr, accept_rd, refused, last_tick, preset_act;
    logic [BYTE_W-1:0] shreg_q;
    logic [2:0] bit_cnt_q;
    logic sel_q;
    logic [ACC_W-1:0] acc_q, acc_next;
    logic step_raw, step_bit;
    logic [CNT_W-1:0] byte_cnt_q;
    logic [2:0] chk_cnt_q;
    logic done_evt, err_evt, ovr_evt;
    logic diag_q;
    logic [STAT_W-1:0] stat_q, mask_q, stat_set, stat_clr;
    logic bus_wr_q;
    logic [7:0] bus_addr_q;
    logic addr_ph;
    logic [31:0] rd_mux;

    dea_tick_div u_div
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick)
    );

    // Accumulator step shared by every operation
    dea_acc_step #(.POLY(POLY)) u_step
    (
        .acc(acc_q),
        .bit_in(step_bit),
        .raw(step_raw),
        .acc_next(acc_next)
    );

    // Reads shift zeros in; diag check bytes shift in raw
    assign step_bit = (state_q == DEA_SHIFT_OUT) ? 1'b0 : shreg_q[BYTE_W-1];
    assign step_raw = (state_q == DEA_SHIFT_OUT) || (diag_q && sel_q);

    // Strobes only count with the device selected
    assign wr_lvl = !cs_n && !write_strobe_n;
    assign rd_lvl = !cs_n && !read_strobe_n && write_strobe_n;
    assign wr_start = wr_lvl && !wr_q;
    assign rd_start = rd_lvl && !rd_q;
    assign accept_wr = wr_start && (state_q == DEA_IDLE);
    assign accept_rd = rd_start && (state_q == DEA_IDLE);
    assign refused = (wr_start || rd_start) && (state_q != DEA_IDLE);
    assign last_tick = tick && (state_q != DEA_IDLE) && (bit_cnt_q == LAST_BIT);
    assign preset_act = !preset_n && long_n;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_lvl;
            rd_q <= rd_lvl;
        end
    end

    // Byte sequencer: eight enables per byte, busy throughout
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= DEA_IDLE;
            shreg_q <= '0;
            bit_cnt_q <= '0;
            sel_q <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                DEA_IDLE:
                begin
                    bit_cnt_q <= '0;
                    if (accept_wr)
                    begin
                        state_q <= DEA_SHIFT_IN;
                        shreg_q <= data_i;
                        sel_q <= ecc_sel;
                        busy <= 1'b1;
                    end
                    else if (accept_rd)
                    begin
                        state_q <= DEA_SHIFT_OUT;
                        sel_q <= ecc_sel;
                        busy <= 1'b1;
                    end
                end
                DEA_SHIFT_IN, DEA_SHIFT_OUT:
                begin
                    if (tick)
                    begin
                        shreg_q <= {shreg_q[BYTE_W-2:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == LAST_BIT)
                        begin
                            state_q <= DEA_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Initialisation wins over a byte in flight
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            acc_q <= ACC_PRESET;
        else if (preset_act)
            acc_q <= ACC_PRESET;
        else if (tick && state_q != DEA_IDLE)
            acc_q <= acc_next;
    end

    // Port drive: only while an accepted read strobe stays low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_o <= '0;
            data_oe <= 1'b0;
        end
        else if (accept_rd)
        begin
            data_o <= acc_q[ACC_W-1 -: BYTE_W];
            data_oe <= 1'b1;
        end
        else if (!rd_lvl)
            data_oe <= 1'b0;
    end

    // Record bookkeeping and syndrome evaluation
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            byte_cnt_q <= '0;
            chk_cnt_q <= '0;
            err <= 1'b0;
            done_evt <= 1'b0;
            err_evt <= 1'b0;
            ovr_evt <= 1'b0;
        end
        else
        begin
            done_evt <= last_tick;
            err_evt <= 1'b0;
            ovr_evt <= 1'b0;
            if (preset_act)
            begin
                byte_cnt_q <= '0;
                chk_cnt_q <= '0;
            end
            else
            begin
                if (accept_wr)
                begin
                    // Saturates; the overrun flag tells software
                    if (byte_cnt_q == RECORD_MAX_BYTES)
                        ovr_evt <= 1'b1;
                    else
                        byte_cnt_q <= byte_cnt_q + 1'b1;
                end
                if (last_tick && state_q == DEA_SHIFT_IN)
                begin
                    if (!sel_q)
                        chk_cnt_q <= '0;
                    else if (chk_cnt_q == CHECK_BYTES - 3'd1)
                    begin
                        chk_cnt_q <= CHECK_BYTES;
                        err <= |acc_next;
                        err_evt <= |acc_next;
                    end
                    else if (chk_cnt_q != CHECK_BYTES)
                        chk_cnt_q <= chk_cnt_q + 1'b1;
                end
            end
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_ph = hsel && htrans[1] && hready;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_wr_q <= 1'b0;
            bus_addr_q <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            bus_wr_q <= addr_ph && hwrite;
            if (addr_ph)
                bus_addr_q <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_CTRL: rd_mux[CTRL_DIAG_BIT] = diag_q;
            OFF_STATUS: rd_mux[STAT_W-1:0] = stat_q;
            OFF_MASK: rd_mux[STAT_W-1:0] = mask_q;
            OFF_ACC: rd_mux = acc_q;
            OFF_COUNT:
            begin
                rd_mux[CNT_W-1:0] = byte_cnt_q;
                rd_mux[CNT_CHK_LSB +: 3] = chk_cnt_q;
                rd_mux[CNT_BUSY_BIT] = busy;
                rd_mux[CNT_ERR_BIT] = err;
            end
            OFF_POLY: rd_mux = POLY;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data sampled in the address phase so it stands from a flop
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= '0;
        else if (addr_ph && !hwrite)
            hrdata <= rd_mux;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            diag_q <= CTRL_RST;
            mask_q <= MASK_RST;
        end
        else if (bus_wr_q)
        begin
            if (bus_addr_q == OFF_CTRL)
                diag_q <= hwdata[CTRL_DIAG_BIT];
            if (bus_addr_q == OFF_MASK)
                mask_q <= hwdata[STAT_W-1:0];
        end
    end

    // Sticky status: a new event beats a same-cycle clear
    always_comb
    begin
        stat_set = '0;
        stat_set[STAT_DONE_BIT] = done_evt;
        stat_set[STAT_REFUSED_BIT] = refused;
        stat_set[STAT_ERR_BIT] = err_evt;
        stat_set[STAT_OVERRUN_BIT] = ovr_evt;
        stat_clr = '0;
        if (bus_wr_q && bus_addr_q == OFF_STATUS)
            stat_clr = hwdata[STAT_W-1:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stat_q <= STAT_RST;
        else
            stat_q <= (stat_q & ~stat_clr) | stat_set;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(stat_q & mask_q);
    end

    logic unused_ok;
    assign unused_ok = ^{haddr[31:8], haddr[1:0], hsize, htrans[0],
        hwdata[31:STAT_W]};
endmodule // dea_ecc_acc
`default_nettype wire

// ===== dea_ecc_acc_asserts.sv
// Checker for the byte-port timing of the ECC accumulator
`default_nettype none
module dea_ecc_acc_asserts
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic preset_n,
    input wire logic busy,
    input wire logic err,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] len_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Busy length in edges; the tick phase is free, so a window of ten
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            len_q <= 8'h00;
        else
            len_q <= busy ? len_q + 8'h01 : 8'h00;
    end
    wr_accept_a: assert property (!cs_n && !write_strobe_n &&
        $past(write_strobe_n) && !busy |=> busy) else $error("no busy");
    rd_accept_a: assert property (!cs_n && !read_strobe_n &&
        $past(read_strobe_n) && write_strobe_n && !busy
        |=> busy && data_oe) else $error("read not started");
    cs_ignore_a: assert property (cs_n && $past(cs_n) && !busy
        |=> !busy) else $error("strobe taken unselected");
    busy_len_a: assert property ($fell(busy) |->
        len_q >= 8'h47 && len_q <= 8'h50) else $error("busy length off");
    rd_refused_a: assert property (busy && !data_oe && !cs_n &&
        !read_strobe_n && $past(read_strobe_n) |=> !data_oe)
        else $error("read taken while busy");
    oe_rise_a: assert property ($rose(data_oe) |->
        !$past(read_strobe_n) && !$past(cs_n))
        else $error("port driven unasked");
    oe_drop_a: assert property ((read_strobe_n || cs_n) [*2]
        |=> !data_oe) else $error("port still driven");
    err_time_a: assert property ($changed(err) && $past(preset_n)
        |-> !busy && ($past(busy) || $past(busy, 2)))
        else $error("err moved outside evaluation");
endmodule // dea_ecc_acc_asserts
bind dea_ecc_acc dea_ecc_acc_asserts u_dea_ecc_acc_asserts
(
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .busy(busy),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .preset_n(preset_n), .err(err), .data_oe(data_oe)
);
`default_nettype wire

// ===== dea_ctrl_model.sv
// Controller model that drives the byte-port strobes
`default_nettype none
module dea_ctrl_model
(
    input wire logic clk_sys,
    input wire logic busy,
    input wire logic [dea_pkg::BYTE_W-1:0] data_o,
    output logic cs_n = 1'h1,
    output logic read_strobe_n = 1'h1,
    output logic write_strobe_n = 1'h1,
    output logic ecc_sel = 1'h0,
    output logic [dea_pkg::BYTE_W-1:0] data_i = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic idle();
        int n = 0;
        while (busy !== 1'h0 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    // A rude transfer skips the idle wait to provoke a refusal
    task automatic xfer(input logic wr, input logic sel, input logic dev,
        input logic rude, input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        if (!rude)
            idle();
        @(posedge clk_sys);
        cs_n <= !dev;
        ecc_sel <= sel;
        data_i <= d;
        if (wr)
            write_strobe_n <= 1'h0;
        else
            read_strobe_n <= 1'h0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (busy !== 1'h1 && n < 6);
        q = data_o;
        @(posedge clk_sys);
        cs_n <= 1'h1;
        read_strobe_n <= 1'h1;
        write_strobe_n <= 1'h1;
        // Released lines show the inverse, never a stale byte
        data_i <= ~d;
    endtask
endmodule // dea_ctrl_model
`default_nettype wire

// ===== tb_dea_ecc_acc.sv
// Self-checking bench for the disk ECC accumulator
`default_nettype none
module tb_dea_ecc_acc;
    timeunit 1ns;
    timeprecision 1ps;
    import dea_pkg::*;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic preset_n = 1'h1;
    logic long_n = 1'h1;
    logic [31:0] hrdata, crc_exp;
    logic hreadyout, hresp, cs_n, read_strobe_n, write_strobe_n, ecc_sel;
    logic [7:0] data_i, data_o;
    logic data_oe, busy, err, irq;
    int failures = 0;
    int n_tests = 0;
    dea_ecc_acc u_dea_ecc_acc
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cs_n(cs_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .ecc_sel(ecc_sel),
        .preset_n(preset_n), .long_n(long_n), .data_i(data_i),
        .data_o(data_o), .data_oe(data_oe), .busy(busy), .err(err), .irq(irq)
    );
    dea_ctrl_model u_dea_ctrl_model
    (
        .clk_sys(clk_sys), .busy(busy), .data_o(data_o), .cs_n(cs_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .ecc_sel(ecc_sel), .data_i(data_i)
    );
    always #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] crc8(input logic [31:0] a,
        input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            a = {a[30:0], 1'h0} ^ ((a[31] ^ b[i]) ? POLY_DEFAULT : 32'h0);
        return a;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do
            @(posedge clk_sys);
        while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do
            @(posedge clk_sys);
        while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'h1, a, d, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input string what);
        logic [31:0] r;
        ahb(1'h0, a, 32'h0, r);
        chk(what, e, r);
    endtask
    // Flags are {write, check byte, selected, rude}
    task automatic px(input logic [3:0] f, input logic [7:0] d,
        output logic [7:0] q);
        u_dea_ctrl_model.xfer(f[3], f[2], f[1], f[0], d, q);
    endtask
    task automatic pulse_preset();
        @(posedge clk_sys);
        preset_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        preset_n <= 1'h1;
    endtask
    task automatic feed();
        logic [7:0] b, q;
        pulse_preset();
        crc_exp = ACC_PRESET;
        b = 8'h5a;
        repeat (3)
        begin
            px(4'ha, b, q);
            crc_exp = crc8(crc_exp, b);
            b = b + 8'h35;
        end
    endtask
    task automatic t_regs();
        rchk(OFF_STATUS, 32'h0, "status");
        rchk(OFF_MASK, 32'h0, "mask");
        rchk(OFF_ACC, ACC_PRESET, "acc");
        rchk(OFF_POLY, POLY_DEFAULT, "poly");
        wr(8'h40, 32'h1234_5678);
        rchk(8'h40, 32'h0, "unmapped");
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("test regs done");
    endtask
    task automatic t_cs();
        logic [7:0] q;
        px(4'h8, 8'h96, q);
        chk("busy", 32'h0, {31'h0, busy});
        rchk(OFF_ACC, ACC_PRESET, "acc");
        $display("test select done");
    endtask
    task automatic t_gen();
        logic [7:0] q;
        feed();
        for (int i = 3; i >= 0; i--)
        begin
            px(4'h6, 8'h00, q);
            chk("check", {24'h0, crc_exp[8*i+:8]}, {24'h0, q});
        end
        // The last read is still shifting until busy falls
        u_dea_ctrl_model.idle();
        rchk(OFF_ACC, 32'h0, "acc");
        $display("test gen done");
    endtask
    // Clean record, single bit error, then an 11-bit burst across bytes
    task automatic t_check();
        logic [31:0] m [3] = '{32'h0, 32'h0000_0001, 32'h0001_ffc0};
        logic [31:0] w;
        logic [7:0] q;
        foreach (m[k])
        begin
            feed();
            w = crc_exp ^ m[k];
            for (int i = 3; i >= 0; i--)
                px(4'he, w[8*i+:8], q);
            u_dea_ctrl_model.idle();
            repeat (2) @(negedge clk_sys);
            chk("err", {31'h0, |m[k]}, {31'h0, err});
        end
        $display("test check done");
    endtask
    task automatic t_long();
        logic [31:0] e;
        e = 32'h0;
        for (int i = 3; i >= 0; i--)
            e = crc8(e, 8'(32'h0001_ffc0 >> (8 * i)));
        @(posedge clk_sys);
        long_n <= 1'h0;
        pulse_preset();
        rchk(OFF_ACC, e, "acc");
        long_n <= 1'h1;
        pulse_preset();
        rchk(OFF_ACC, ACC_PRESET, "acc");
        $display("test long done");
    endtask
    // Diagnostic mode: check bytes go in and come back raw
    task automatic t_diag();
        logic [31:0] v;
        logic [7:0] q;
        v = 32'h1234_5678;
        wr(OFF_CTRL, 32'h1);
        pulse_preset();
        for (int i = 3; i >= 0; i--)
            px(4'he, v[8*i+:8], q);
        u_dea_ctrl_model.idle();
        rchk(OFF_COUNT, 32'h0204_0004, "count");
        for (int i = 3; i >= 0; i--)
        begin
            px(4'h6, 8'h00, q);
            chk("raw", {24'h0, v[8*i+:8]}, {24'h0, q});
        end
        u_dea_ctrl_model.idle();
        wr(OFF_CTRL, 32'h0);
        $display("test diag done");
    endtask
    task automatic t_irq();
        logic [7:0] q;
        wr(OFF_STATUS, 32'hf);
        wr(OFF_MASK, 32'h0);
        px(4'ha, 8'h3c, q);
        px(4'h7, 8'h00, q);
        u_dea_ctrl_model.idle();
        rchk(OFF_STATUS, 32'h3, "status");
        chk("irq", 32'h0, {31'h0, irq});
        wr(OFF_MASK, 32'h2);
        repeat (2) @(negedge clk_sys);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFF_STATUS, 32'h2);
        repeat (2) @(negedge clk_sys);
        chk("irq", 32'h0, {31'h0, irq});
        rchk(OFF_STATUS, 32'h1, "status");
        $display("test irq done");
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_regs();
        t_cs();
        t_gen();
        t_check();
        t_long();
        t_diag();
        t_irq();
        print_verdict();
    end
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end
endmodule // tb_dea_ecc_acc
`default_nettype wire
